// ==== hw/ext_irq_pkg.sv ====
package ext_irq_pkg;

	// byte addresses of the word-aligned registers
	localparam logic [3:0] OFS_CTRL_ZERO = 4'h0;
	localparam logic [3:0] OFS_CTRL_ONE  = 4'h4;
	localparam logic [3:0] OFS_EXT_FLAGS = 4'h8;
	localparam logic [3:0] OFS_DMA_FLAGS = 4'hC;

	localparam int BIT_NMI_LEVEL = 15;
	localparam int BIT_NMI_EDGE  = 8;

	localparam int NUM_PINS = 6;
	localparam int NUM_DMA  = 4;
	localparam int NUM_SYNC = NUM_PINS + 1;

	localparam logic       RST_NMI_EDGE = 1'h0;
	localparam logic [5:0] RST_FLAGS    = 6'h00;
	localparam logic [3:0] ENC_NONE     = 4'hF;

	typedef enum logic [1:0] {
		SENSE_FALL = 2'b00,
		SENSE_RISE = 2'b01,
		SENSE_LOW  = 2'b10,
		SENSE_RSVD = 2'b11
	} sense_t;

	typedef struct packed {
		logic            mask_all_on_low;
		logic            encoded_level_mode;
		logic            block_bit_nonmaskable_gate;
		logic            rsvd12;
		logic [5:0][1:0] pin_sense;
	} ctrl_one_t;

	localparam ctrl_one_t RST_CTRL_ONE = 16'h4000;

endpackage : ext_irq_pkg

// ==== hw/ext_irq_sense.sv ====
// Function
// R1: ctrl zero bit 15 reads nonmaskable pin level
// R2: reserved bits read back as zero
// R3: ctrl zero bit 8 picks nonmaskable edge
// R4: mask-all masks requests while nonmaskable pin low
// R5: mask-all also masks nonmaskable during standby
// R6: bit 14 selects independent or encoded pins
// R7: bit 13 gates nonmaskable by block bit
// R8: two-bit sense: fall, rise, low, reserved
// R9: sense fields at bits 11:0, reset zero
// R10: request flags for pins 5..0, reset zero
// R11: software reads then writes zero to clear
// R12: flags accept only writes of zero
// R13: edge mode latches flag until cleared
// R14: level mode flag follows the pin
// R15: dma end flags at bits 3..0, read-only
// R16: dma register bits 7..4 read zero
// R17: dma register bit 0 is channel 0
// R18: ctrl zero resets to zero, pin bit aside
// R19: detection runs on the peripheral clock
// R20: pins pass two-stage synchroniser first
// R21: encoded mode never sets flags 3..0
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_sense (
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_nmi_pin,
	input  wire logic [5:0]  i_req_pin,
	input  wire logic        i_standby,
	input  wire logic        i_block_bit,
	input  wire logic [3:0]  i_dma_end,
	output logic [5:0]       o_ext_request,
	output logic [3:0]       o_encoded_request_bus,
	output logic             o_nmi_request,
	output logic             o_mask_all_active
);

	// synchroniser: bit 6 is the nonmaskable pin
	logic [6:0] sync1_r, sync1_nxt;
	logic [6:0] sync2_r, sync2_nxt;
	logic [6:0] prev_r, prev_nxt;

	always_comb begin
		sync1_nxt = {i_nmi_pin, i_req_pin}; // [R20]
		sync2_nxt = sync1_r;
		prev_nxt  = sync2_r;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin // [R19]
		if (!i_arst_n) begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
			prev_r  <= 7'h00;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r  <= prev_nxt;
		end
	end

	logic       nmi_lvl;
	logic [5:0] pin_lvl;
	logic [5:0] pin_prev;
	assign nmi_lvl  = sync2_r[ext_irq_pkg::NUM_PINS];
	assign pin_lvl  = sync2_r[5:0];
	assign pin_prev = prev_r[5:0];

	// registers and bus answer
	logic                   nmi_edge_r, nmi_edge_nxt;
	ext_irq_pkg::ctrl_one_t ctrl1_r, ctrl1_nxt;
	logic [5:0]             flag_r, flag_nxt;
	logic                   ack_r, ack_nxt;
	logic [31:0]            rdata_r, rdata_nxt;
	logic                   nmi_req_r, nmi_req_nxt;
	logic [3:0]             enc_r, enc_nxt;

	logic       bus_req;
	logic       wr_take;
	logic       mask_low;
	logic [5:0] set_vec;
	logic [5:0] level_vec;
	logic [5:0] clr_vec;
	logic       nmi_hit;
	logic       nmi_blocked;

	assign bus_req           = i_avs_read | i_avs_write;
	// one wait cycle per access; the write lands when waitrequest is low
	assign o_avs_waitrequest = bus_req & ~ack_r;
	assign wr_take           = i_avs_write & ack_r;
	assign mask_low = ctrl1_r.mask_all_on_low & ~nmi_lvl; // [R4]

	always_comb begin
		set_vec   = 6'h00;
		level_vec = 6'h00;
		for (int i = 0; i < ext_irq_pkg::NUM_PINS; i++) begin
			unique case (ext_irq_pkg::sense_t'(ctrl1_r.pin_sense[i])) // [R8]
				ext_irq_pkg::SENSE_FALL: begin
					set_vec[i] = pin_prev[i] & ~pin_lvl[i]; // [R13]
				end
				ext_irq_pkg::SENSE_RISE: begin
					set_vec[i] = ~pin_prev[i] & pin_lvl[i]; // [R13]
				end
				ext_irq_pkg::SENSE_LOW: begin
					level_vec[i] = 1'b1;
					set_vec[i]   = ~pin_lvl[i]; // [R14]
				end
				default: begin
					// prohibited code: the pin raises nothing
					set_vec[i] = 1'b0;
				end
			endcase
		end
		if (ctrl1_r.encoded_level_mode) begin
			// pins 3..0 carry a level code, not requests
			set_vec[3:0] = 4'h0; // [R21]
		end
	end

	always_comb begin
		clr_vec = 6'h00;
		if (wr_take && i_avs_address == ext_irq_pkg::OFS_EXT_FLAGS &&
		    i_avs_byteenable[0]) begin
			clr_vec = ~i_avs_writedata[5:0]; // [R12]
		end
		// an edge in the clearing cycle wins over the clear
		flag_nxt = set_vec | (flag_r & ~clr_vec & ~level_vec); // [R13] [R14]
	end

	always_comb begin
		nmi_hit = 1'b0;
		if (nmi_edge_r) begin
			nmi_hit = ~prev_r[6] & nmi_lvl; // [R3]
		end else begin
			nmi_hit = prev_r[6] & ~nmi_lvl; // [R3]
		end
		nmi_blocked = (i_block_bit & ~ctrl1_r.block_bit_nonmaskable_gate) // [R7]
		            | (ctrl1_r.mask_all_on_low & i_standby); // [R5]
		nmi_req_nxt = nmi_hit & ~nmi_blocked;
		enc_nxt     = ext_irq_pkg::ENC_NONE;
		if (ctrl1_r.encoded_level_mode && !mask_low) begin
			enc_nxt = pin_lvl[3:0]; // [R6]
		end
	end

	always_comb begin
		nmi_edge_nxt = nmi_edge_r;
		ctrl1_nxt    = ctrl1_r;
		ack_nxt      = bus_req & ~ack_r;
		rdata_nxt    = rdata_r;
		if (wr_take && i_avs_address == ext_irq_pkg::OFS_CTRL_ZERO &&
		    i_avs_byteenable[1]) begin
			nmi_edge_nxt = i_avs_writedata[ext_irq_pkg::BIT_NMI_EDGE];
		end
		if (wr_take && i_avs_address == ext_irq_pkg::OFS_CTRL_ONE) begin
			if (i_avs_byteenable[0]) begin
				ctrl1_nxt[7:0] = i_avs_writedata[7:0]; // [R9]
			end
			if (i_avs_byteenable[1]) begin
				ctrl1_nxt[15:8] = i_avs_writedata[15:8];
			end
			ctrl1_nxt.rsvd12 = 1'b0; // [R2]
		end
		if (i_avs_read && !ack_r) begin
			rdata_nxt = 32'h0000_0000; // [R2] [R16]
			unique case (i_avs_address)
				ext_irq_pkg::OFS_CTRL_ZERO: begin
					rdata_nxt[ext_irq_pkg::BIT_NMI_LEVEL] = nmi_lvl; // [R1]
					rdata_nxt[ext_irq_pkg::BIT_NMI_EDGE]  = nmi_edge_r;
				end
				ext_irq_pkg::OFS_CTRL_ONE: begin
					rdata_nxt[15:0] = ctrl1_r;
				end
				ext_irq_pkg::OFS_EXT_FLAGS: begin
					rdata_nxt[5:0] = flag_r; // [R10]
				end
				ext_irq_pkg::OFS_DMA_FLAGS: begin
					rdata_nxt[3:0] = i_dma_end; // [R15] [R17]
				end
				default: begin
					rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			nmi_edge_r <= ext_irq_pkg::RST_NMI_EDGE; // [R18]
			ctrl1_r    <= ext_irq_pkg::RST_CTRL_ONE; // [R6] [R9]
			flag_r     <= ext_irq_pkg::RST_FLAGS; // [R10]
			ack_r      <= 1'b0;
			rdata_r    <= 32'h0000_0000;
			nmi_req_r  <= 1'b0;
			enc_r      <= ext_irq_pkg::ENC_NONE;
		end else begin
			nmi_edge_r <= nmi_edge_nxt;
			ctrl1_r    <= ctrl1_nxt;
			flag_r     <= flag_nxt;
			ack_r      <= ack_nxt;
			rdata_r    <= rdata_nxt;
			nmi_req_r  <= nmi_req_nxt;
			enc_r      <= enc_nxt;
		end
	end

	assign o_avs_readdata        = rdata_r;
	assign o_ext_request         = flag_r & {6{~mask_low}}; // [R4]
	assign o_encoded_request_bus = enc_r;
	assign o_nmi_request         = nmi_req_r;
	assign o_mask_all_active     = mask_low;

	a_nmi_level_read: assert property (@(posedge i_ref_clk) // [R1]
		disable iff (!i_arst_n)
		(i_avs_read && !ack_r && i_avs_address == ext_irq_pkg::OFS_CTRL_ZERO)
		|=> o_avs_readdata[15] == $past(nmi_lvl))
		else $error("pin level bit wrong");

	a_rsvd_reads_zero: assert property (@(posedge i_ref_clk) // [R2]
		disable iff (!i_arst_n)
		(i_avs_read && !ack_r && i_avs_address == ext_irq_pkg::OFS_CTRL_ZERO)
		|=> (o_avs_readdata[14:9] == 6'h00 && o_avs_readdata[7:0] == 8'h00))
		else $error("reserved bits not zero");

	a_dma_upper_zero: assert property (@(posedge i_ref_clk) // [R16]
		disable iff (!i_arst_n)
		(i_avs_read && !ack_r && i_avs_address == ext_irq_pkg::OFS_DMA_FLAGS)
		|=> o_avs_readdata[7:0] == {4'h0, $past(i_dma_end)})
		else $error("dma flags read wrong");

	a_mask_all_low: assert property (@(posedge i_ref_clk) // [R4]
		disable iff (!i_arst_n)
		(ctrl1_r.mask_all_on_low && !nmi_lvl) |-> o_ext_request == 6'h00)
		else $error("requests pass while masked");

	a_nmi_gate: assert property (@(posedge i_ref_clk) // [R7]
		disable iff (!i_arst_n)
		o_nmi_request |-> !$past(i_block_bit &&
			!ctrl1_r.block_bit_nonmaskable_gate) && $past(nmi_hit))
		else $error("nonmaskable passed block");

	a_nmi_standby: assert property (@(posedge i_ref_clk) // [R5]
		disable iff (!i_arst_n)
		(ctrl1_r.mask_all_on_low && i_standby) |=> !o_nmi_request)
		else $error("nonmaskable passed standby");

	a_no_sw_set: assert property (@(posedge i_ref_clk) // [R12]
		disable iff (!i_arst_n)
		1'b1 |=> (flag_r & ~$past(flag_r) & ~$past(set_vec)) == 6'h00)
		else $error("flag set without event");

	a_edge_latch: assert property (@(posedge i_ref_clk) // [R13]
		disable iff (!i_arst_n)
		(ctrl1_r.pin_sense[5] == 2'b00 && pin_prev[5] && !pin_lvl[5])
		##1 (!wr_take [*2]) |-> flag_r[5] && $past(flag_r[5]))
		else $error("edge flag not latched");

	a_level_follow: assert property (@(posedge i_ref_clk) // [R14]
		disable iff (!i_arst_n)
		ctrl1_r.pin_sense[4] == 2'b10 |=> flag_r[4] == !$past(pin_lvl[4]))
		else $error("level flag not following");

	a_encoded_quiet: assert property (@(posedge i_ref_clk) // [R21]
		disable iff (!i_arst_n)
		(ctrl1_r.encoded_level_mode && flag_r[3:0] == 4'h0)
		|=> flag_r[3:0] == 4'h0)
		else $error("encoded pins set flags");

	a_bus_one_wait: assert property (@(posedge i_ref_clk) // one wait cycle per access
		disable iff (!i_arst_n)
		(bus_req && o_avs_waitrequest) |=> !o_avs_waitrequest)
		else $error("bus answer late");

	a_flag_clear_zero: assert property (@(posedge i_ref_clk) // [R12]
		disable iff (!i_arst_n)
		(wr_take && i_avs_address == ext_irq_pkg::OFS_EXT_FLAGS &&
		 i_avs_byteenable[0] && !i_avs_writedata[5] && !set_vec[5])
		|=> !flag_r[5])
		else $error("flag not cleared by zero");

	a_enc_masked: assert property (@(posedge i_ref_clk) // [R4]
		disable iff (!i_arst_n)
		mask_low |=> o_encoded_request_bus == ext_irq_pkg::ENC_NONE)
		else $error("encoded bus passes while masked");

	a_ctrl_one_rsvd: assert property (@(posedge i_ref_clk) // [R2]
		disable iff (!i_arst_n)
		(i_avs_read && !ack_r && i_avs_address == ext_irq_pkg::OFS_CTRL_ONE)
		|=> (o_avs_readdata[12] == 1'b0 &&
		     o_avs_readdata[31:16] == 16'h0000))
		else $error("control one reserved bits set");

	a_dma_chan_zero: assert property (@(posedge i_ref_clk) // [R17]
		disable iff (!i_arst_n)
		(i_avs_read && !ack_r && i_avs_address == ext_irq_pkg::OFS_DMA_FLAGS)
		|=> o_avs_readdata[0] == $past(i_dma_end[0]))
		else $error("dma channel zero flag wrong");

	// an edge-select write can legally turn one pin swing into two pulses
	a_nmi_one_cycle: assert property (@(posedge i_ref_clk) // [R3]
		disable iff (!i_arst_n)
		(o_nmi_request && $stable(nmi_edge_r)) |=> !o_nmi_request)
		else $error("nonmaskable pulse too long");

endmodule : ext_irq_sense
`default_nettype wire

// ==== verification/ext_pin_source.sv ====
`timescale 1ns/100ps
`default_nettype none
// pins move just after the clock edge; the design still has to synchronise
module ext_pin_source (
	input  wire logic       i_ref_clk,
	input  wire logic [5:0] i_req_cmd,
	input  wire logic       i_nmi_cmd,
	output logic [5:0]      o_req_pin,
	output logic            o_nmi_pin
);
	always @(posedge i_ref_clk) begin
		o_req_pin <= i_req_cmd;
		o_nmi_pin <= i_nmi_cmd;
	end
endmodule : ext_pin_source
`default_nettype wire

// ==== verification/tb_external_interrupt_sense_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_external_interrupt_sense_control;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        wait_req;
	logic [5:0]  pin_cmd = 6'h3D;
	logic        nmi_cmd = 1'b1;
	logic [5:0]  req_pin;
	logic        nmi_pin;
	logic        stby = 1'b0;
	logic        blk = 1'b0;
	logic [3:0]  dma = 4'h0;
	logic [5:0]  ext_req;
	logic [3:0]  enc_bus;
	logic        nmi_req;
	logic        mask_act;
	logic [31:0] got;
	int          error_cnt = 0;
	int          compares = 0;
	int          pulses;
	// nmi cases: edge select, control one, {block, standby}, pulse expected
	logic [15:0] t_c0[5] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0100};
	logic [15:0] t_c1[5] = '{16'h0, 16'h0, 16'h2000, 16'h8000, 16'h0};
	logic [1:0]  t_bs[5] = '{2'b00, 2'b10, 2'b10, 2'b01, 2'b00};
	logic        t_ex[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	always #20 clk = ~clk;

	ext_pin_source i_src (
		.i_ref_clk(clk), .i_req_cmd(pin_cmd), .i_nmi_cmd(nmi_cmd),
		.o_req_pin(req_pin), .o_nmi_pin(nmi_pin));

	ext_irq_sense i_dut (
		.i_ref_clk(clk), .i_arst_n(arst_n), .i_avs_address(adr),
		.i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wait_req), .i_nmi_pin(nmi_pin),
		.i_req_pin(req_pin), .i_standby(stby), .i_block_bit(blk),
		.i_dma_end(dma), .o_ext_request(ext_req),
		.o_encoded_request_bus(enc_bus), .o_nmi_request(nmi_req),
		.o_mask_all_active(mask_act));

	task complete_run;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// one access; waitrequest is sampled at each rising edge
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wdat <= d;
		rd_en <= !w;
		wr_en <= w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		if (wait_req !== 1'b0) begin
			error_cnt++;
			complete_run();
		end
		got = rdat;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask : bus

	task rd_chk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(got, e);
	endtask : rd_chk

	// pins need two sync edges plus detection before they show
	task pins(input logic [5:0] p, input logic v);
		@(posedge clk);
		pin_cmd <= p;
		nmi_cmd <= v;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask : pins

	task nmi_to(input logic v);
		@(posedge clk);
		nmi_cmd <= v;
		pulses = 0;
		repeat (8) begin
			@(negedge clk);
			pulses += int'(nmi_req === 1'b1);
		end
	endtask : nmi_to

	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		// let the pin level pass both synchroniser stages first
		repeat (4) @(posedge clk);
		rd_chk(ext_irq_pkg::OFS_CTRL_ZERO, 32'h8000);
		rd_chk(ext_irq_pkg::OFS_CTRL_ONE, 32'h4000);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h0);
		rd_chk(ext_irq_pkg::OFS_DMA_FLAGS, 32'h0);
		$display("test reset done");
		bus(1'b1, ext_irq_pkg::OFS_CTRL_ZERO, 32'hFFFF_FFFF);
		rd_chk(ext_irq_pkg::OFS_CTRL_ZERO, 32'h8100);
		bus(1'b1, ext_irq_pkg::OFS_CTRL_ONE, 32'hFFFF_FAAA);
		rd_chk(ext_irq_pkg::OFS_CTRL_ONE, 32'hEAAA);
		$display("test control done");
		// pin0 falling, pin1 rising, pin2 low level
		bus(1'b1, ext_irq_pkg::OFS_CTRL_ONE, 32'h0024);
		pins(6'h3A, 1'b1);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h07);
		chk(32'(ext_req), 32'h07);
		pins(6'h3D, 1'b1);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h03);
		bus(1'b1, ext_irq_pkg::OFS_EXT_FLAGS, 32'hFE);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h02);
		pins(6'h1D, 1'b1);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h22);
		bus(1'b1, ext_irq_pkg::OFS_EXT_FLAGS, 32'hFF);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h22);
		bus(1'b1, ext_irq_pkg::OFS_EXT_FLAGS, 32'hDF);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h02);
		$display("test flags done");
		bus(1'b1, ext_irq_pkg::OFS_CTRL_ONE, 32'h4000);
		pins(6'h35, 1'b1);
		rd_chk(ext_irq_pkg::OFS_EXT_FLAGS, 32'h02);
		chk(32'(enc_bus), 32'h5);
		bus(1'b1, ext_irq_pkg::OFS_CTRL_ONE, 32'hC000);
		pins(6'h35, 1'b0);
		chk(32'({mask_act, enc_bus, ext_req}), 32'h7C0);
		pins(6'h35, 1'b1);
		$display("test encoded done");
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, ext_irq_pkg::OFS_CTRL_ZERO, {16'h0, t_c0[i]});
			bus(1'b1, ext_irq_pkg::OFS_CTRL_ONE, {16'h0, t_c1[i]});
			@(posedge clk);
			{blk, stby} <= t_bs[i];
			nmi_to(1'b0);
			chk(32'(pulses), 32'(t_ex[i] & ~t_c0[i][8]));
			chk(32'(mask_act), 32'(t_c1[i][15]));
			rd_chk(ext_irq_pkg::OFS_CTRL_ZERO, {16'h0, t_c0[i]});
			nmi_to(1'b1);
			chk(32'(pulses), 32'(t_ex[i] & t_c0[i][8]));
		end
		$display("test nmi done");
		@(posedge clk);
		dma <= 4'hB;
		rd_chk(ext_irq_pkg::OFS_DMA_FLAGS, 32'h0B);
		rd_chk(4'h2, 32'h0);
		$display("test dma done");
		complete_run();
	end
endmodule : tb_external_interrupt_sense_control
`default_nettype wire
